// ### rtl/adcc_pkg.sv
// Purpose: Shared constants and types of the converter and comparator control.
// Assumes: Register bus with byte addresses and 32-bit data.
// Notes:   All offsets, field positions and timing counts live here.
package adcc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] RES_OFS    = 8'h08;
  localparam logic [7:0] ACC_OFS    = 8'h0C;
  localparam logic [7:0] CMPC_OFS   = 8'h10;
  // ----------------------------------------
  // Control, status and comparator fields
  // ----------------------------------------
  localparam int C_START  = 0;
  localparam int C_CONT   = 1;
  localparam int C_CHAN   = 2;
  localparam int C_DIV    = 5;
  localparam int C_SMP    = 7;
  localparam int C_GAIN   = 9;
  localparam int C_REFX   = 10;
  localparam int C_ACCEN  = 11;
  localparam int C_ACCN   = 12;
  localparam int C_ACCIRQ = 14;
  localparam int C_IRQEN  = 15;
  localparam int S_BUSY   = 0;
  localparam int S_DONE   = 1;
  localparam int S_ACCD   = 2;
  localparam int S_CMP    = 3;
  localparam int S_CEDGE  = 4;
  localparam int K_EN     = 0;
  localparam int K_LP     = 1;
  localparam int K_HYST   = 2;
  localparam int K_NEG    = 4;
  localparam int K_POS    = 6;
  localparam int K_WAKE   = 7;
  localparam int K_FALL   = 8;
  localparam int K_IRQEN  = 9;
  // ----------------------------------------
  // Channels, sources and timing
  // ----------------------------------------
  localparam logic [2:0] CHAN_SUPPLY = 3'h5;
  localparam logic [2:0] CHAN_LAST   = 3'h5;
  localparam logic [1:0] NEG_ILLEGAL = 2'h3;
  localparam int SRC_HZ     = 16000000;
  localparam int ADC_MAX_HZ = 2000000;
  localparam int DIV_BASE   = SRC_HZ / ADC_MAX_HZ;
  localparam int SAR_BITS   = 8;
  localparam int SAMP_MULT  = 3;
  localparam int CONV_EXTRA = 10;
  localparam int HOLD_EXTRA = CONV_EXTRA - SAR_BITS;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CMPC_RST = 32'h0000_0000;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SAMP = 4'h2,
    ST_HOLD = 4'h4,
    ST_CONV = 4'h8
  } adcc_state_type;
endpackage : adcc_pkg

// ### rtl/adcc_top.sv
// Purpose: Control of an 8-bit successive-approximation converter and one comparator.
// Assumes: SRC_TICK is a one-cycle enable at the 16 MHz source rate from logic on CLK.
// Notes:   ADC_CMP and CMP_OUT come from analogue circuitry and are synchronised here.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module adcc_top #(
  parameter int ACC_W = 12
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        SRC_TICK,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        ADC_CMP,
  output logic             ADC_SAMPLE,
  output logic      [2:0]  ADC_CHAN,
  output logic      [7:0]  ADC_TRIAL,
  output logic             ADC_GAIN,
  output logic             ADC_REF_EXT,
  output logic             ADC_SUPMON_EN,
  output logic             ADC_IRQ,
  input  wire logic        SLEEP,
  input  wire logic        CMP_OUT,
  output logic             CMP_EN,
  output logic             CMP_LOWPWR,
  output logic      [1:0]  CMP_HYST,
  output logic      [1:0]  CMP_NEG_SEL,
  output logic             CMP_POS_SEL,
  output logic             CMP_IRQ,
  output logic             WAKE
);
  if (ACC_W < adcc_pkg::SAR_BITS + 4) begin : g_chk
    $error("ACC_W too narrow for a sum of 16 results");
  end
  // ----------------------------------------
  // Reset release and declarations
  // ----------------------------------------
  logic [1:0] rst_s_q;
  logic       rst_n;
  adcc_pkg::adcc_state_type st_q;
  logic [5:0] div_cnt_q;
  logic [5:0] div_top;
  logic       adc_tk_q;
  logic       start_q;
  logic       cont_q;
  logic [2:0] chan_q;
  logic [1:0] div_q;
  logic [1:0] smp_q;
  logic       gain_q;
  logic       refx_q;
  logic       acc_en_q;
  logic [1:0] accn_q;
  logic       acc_irq_q;
  logic       irq_en_q;
  logic [4:0] cnt_q;
  logic [2:0] bit_q;
  logic [7:0] trial_q;
  logic [7:0] trial_d;
  logic [7:0] res_q;
  logic       done_q;
  logic       samp_q;
  logic       sup_q;
  logic [4:0] samp_n;
  logic [4:0] hold_n;
  logic [2:0] acmp_s_q;
  logic       acmp_f_q;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] accsum_q;
  logic [ACC_W-1:0] acc_add;
  logic [3:0] acc_cnt_q;
  logic [3:0] acc_top;
  logic       acc_last_q;
  logic       done_f_q;
  logic       acc_f_q;
  logic       irq_q;
  logic [2:0] cmp_s_q;
  logic       cmp_f_q;
  logic       cmp_chg;
  logic       cmp_act;
  logic       cedge_f_q;
  logic       cen_q;
  logic       clp_q;
  logic [1:0] chys_q;
  logic [1:0] cneg_q;
  logic       cpos_q;
  logic       cwake_q;
  logic       cfall_q;
  logic       cirq_en_q;
  logic       cirq_q;
  logic       wake_q;
  logic       lp_out_q;
  logic [31:0] rdata_q;
  logic       wr_ctrl;
  logic       wr_stat;
  logic       wr_cmpc;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s_q <= 2'h0;
    end else begin
      rst_s_q <= {rst_s_q[0], 1'b1};
    end
  end
  assign rst_n = rst_s_q[1];

  assign wr_ctrl = WR && (ADDR == adcc_pkg::CTRL_OFS);
  assign wr_stat = WR && (ADDR == adcc_pkg::STAT_OFS);
  assign wr_cmpc = WR && (ADDR == adcc_pkg::CMPC_OFS);
  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cont_q    <= adcc_pkg::CTRL_RST[adcc_pkg::C_CONT];
      chan_q    <= adcc_pkg::CTRL_RST[adcc_pkg::C_CHAN+:3];
      div_q     <= adcc_pkg::CTRL_RST[adcc_pkg::C_DIV+:2];
      smp_q     <= adcc_pkg::CTRL_RST[adcc_pkg::C_SMP+:2];
      gain_q    <= adcc_pkg::CTRL_RST[adcc_pkg::C_GAIN];
      refx_q    <= adcc_pkg::CTRL_RST[adcc_pkg::C_REFX];
      acc_en_q  <= adcc_pkg::CTRL_RST[adcc_pkg::C_ACCEN];
      accn_q    <= adcc_pkg::CTRL_RST[adcc_pkg::C_ACCN+:2];
      acc_irq_q <= adcc_pkg::CTRL_RST[adcc_pkg::C_ACCIRQ];
      irq_en_q  <= adcc_pkg::CTRL_RST[adcc_pkg::C_IRQEN];
    end else if (wr_ctrl) begin
      cont_q    <= WDATA[adcc_pkg::C_CONT];
      if (WDATA[adcc_pkg::C_CHAN+:3] <= adcc_pkg::CHAN_LAST) begin
        chan_q  <= WDATA[adcc_pkg::C_CHAN+:3];
      end
      div_q     <= WDATA[adcc_pkg::C_DIV+:2];
      smp_q     <= WDATA[adcc_pkg::C_SMP+:2];
      gain_q    <= WDATA[adcc_pkg::C_GAIN];
      refx_q    <= WDATA[adcc_pkg::C_REFX];
      acc_en_q  <= WDATA[adcc_pkg::C_ACCEN];
      accn_q    <= WDATA[adcc_pkg::C_ACCN+:2];
      acc_irq_q <= WDATA[adcc_pkg::C_ACCIRQ];
      irq_en_q  <= WDATA[adcc_pkg::C_IRQEN];
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cen_q     <= adcc_pkg::CMPC_RST[adcc_pkg::K_EN];
      clp_q     <= adcc_pkg::CMPC_RST[adcc_pkg::K_LP];
      chys_q    <= adcc_pkg::CMPC_RST[adcc_pkg::K_HYST+:2];
      cneg_q    <= adcc_pkg::CMPC_RST[adcc_pkg::K_NEG+:2];
      cpos_q    <= adcc_pkg::CMPC_RST[adcc_pkg::K_POS];
      cwake_q   <= adcc_pkg::CMPC_RST[adcc_pkg::K_WAKE];
      cfall_q   <= adcc_pkg::CMPC_RST[adcc_pkg::K_FALL];
      cirq_en_q <= adcc_pkg::CMPC_RST[adcc_pkg::K_IRQEN];
    end else if (wr_cmpc) begin
      cen_q     <= WDATA[adcc_pkg::K_EN];
      clp_q     <= WDATA[adcc_pkg::K_LP];
      chys_q    <= WDATA[adcc_pkg::K_HYST+:2];
      if (WDATA[adcc_pkg::K_NEG+:2] != adcc_pkg::NEG_ILLEGAL) begin
        cneg_q  <= WDATA[adcc_pkg::K_NEG+:2];
      end
      cpos_q    <= WDATA[adcc_pkg::K_POS];
      cwake_q   <= WDATA[adcc_pkg::K_WAKE];
      cfall_q   <= WDATA[adcc_pkg::K_FALL];
      cirq_en_q <= WDATA[adcc_pkg::K_IRQEN];
    end
  end
  // ----------------------------------------
  // Converter clock divider
  // ----------------------------------------
  assign div_top = 6'((adcc_pkg::DIV_BASE << div_q) - 1);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 6'h00;
      adc_tk_q  <= 1'b0;
    end else begin
      adc_tk_q <= SRC_TICK && (div_cnt_q >= div_top);
      if (SRC_TICK) begin
        div_cnt_q <= (div_cnt_q >= div_top) ? 6'h00 : 6'(div_cnt_q + 6'h01);
      end
    end
  end
  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  assign samp_n = 5'(({3'h0, smp_q} + 5'h01) << 1);
  assign hold_n = 5'((samp_n << 1) + 5'(adcc_pkg::HOLD_EXTRA));

  // Comparator high means the input is at or above the trial code, so the bit stays.
  always_comb begin
    trial_d = trial_q;
    if (!acmp_f_q) begin
      trial_d[bit_q] = 1'b0;
    end
    if (bit_q != 3'h0) begin
      trial_d[3'(bit_q - 3'h1)] = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= adcc_pkg::ST_IDLE;
      cnt_q   <= 5'h00;
      bit_q   <= 3'h0;
      trial_q <= 8'h00;
      res_q   <= 8'h00;
      done_q  <= 1'b0;
      samp_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (adc_tk_q) begin
        unique case (st_q)
          adcc_pkg::ST_IDLE: begin
            if (start_q) begin
              st_q   <= adcc_pkg::ST_SAMP;
              samp_q <= 1'b1;
              cnt_q  <= 5'(samp_n - 5'h01);
            end
          end
          adcc_pkg::ST_SAMP: begin
            if (cnt_q == 5'h00) begin
              st_q   <= adcc_pkg::ST_HOLD;
              samp_q <= 1'b0;
              cnt_q  <= 5'(hold_n - 5'h01);
            end else begin
              cnt_q <= 5'(cnt_q - 5'h01);
            end
          end
          adcc_pkg::ST_HOLD: begin
            if (cnt_q == 5'h00) begin
              st_q    <= adcc_pkg::ST_CONV;
              trial_q <= 8'h80;
              bit_q   <= 3'h7;
            end else begin
              cnt_q <= 5'(cnt_q - 5'h01);
            end
          end
          adcc_pkg::ST_CONV: begin
            trial_q <= trial_d;
            if (bit_q == 3'h0) begin
              res_q  <= trial_d;
              done_q <= 1'b1;
              if (cont_q) begin
                st_q   <= adcc_pkg::ST_SAMP;
                samp_q <= 1'b1;
                cnt_q  <= 5'(samp_n - 5'h01);
              end else begin
                st_q <= adcc_pkg::ST_IDLE;
              end
            end else begin
              bit_q <= 3'(bit_q - 3'h1);
            end
          end
        endcase
      end
    end
  end

  // A start written while busy is remembered and runs after the current one.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
      sup_q   <= 1'b0;
    end else begin
      if (wr_ctrl && WDATA[adcc_pkg::C_START]) begin
        start_q <= 1'b1;
      end else if (adc_tk_q && (st_q == adcc_pkg::ST_IDLE)) begin
        start_q <= 1'b0;
      end
      sup_q <= (chan_q == adcc_pkg::CHAN_SUPPLY) && (start_q || (st_q != adcc_pkg::ST_IDLE));
    end
  end
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      acmp_s_q <= 3'h0;
      acmp_f_q <= 1'b0;
      cmp_s_q  <= 3'h0;
      cmp_f_q  <= 1'b0;
    end else begin
      acmp_s_q <= {acmp_s_q[1:0], ADC_CMP};
      cmp_s_q  <= {cmp_s_q[1:0], CMP_OUT};
      if (acmp_s_q[1] == acmp_s_q[2]) begin
        acmp_f_q <= acmp_s_q[2];
      end
      if (cmp_s_q[1] == cmp_s_q[2]) begin
        cmp_f_q <= cmp_s_q[2];
      end
    end
  end
  assign cmp_chg = cen_q && (cmp_s_q[1] == cmp_s_q[2]) && (cmp_s_q[2] != cmp_f_q);
  assign cmp_act = cmp_chg && (cmp_s_q[2] != cfall_q);
  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  assign acc_top = 4'((4'h2 << accn_q) - 4'h1);
  assign acc_add = ACC_W'(acc_q + {{(ACC_W-8){1'b0}}, res_q});

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      acc_q      <= '0;
      accsum_q   <= '0;
      acc_cnt_q  <= 4'h0;
      acc_last_q <= 1'b0;
    end else begin
      acc_last_q <= 1'b0;
      if (!acc_en_q) begin
        acc_cnt_q <= 4'h0;
      end else if (done_q) begin
        if (acc_cnt_q == 4'h0) begin
          acc_q <= {{(ACC_W-8){1'b0}}, res_q};
        end else begin
          acc_q <= acc_add;
        end
        if (acc_cnt_q >= acc_top) begin
          accsum_q   <= acc_add;
          acc_last_q <= 1'b1;
          acc_cnt_q  <= 4'h0;
        end else begin
          acc_cnt_q <= 4'(acc_cnt_q + 4'h1);
        end
      end
    end
  end
  // ----------------------------------------
  // Flags, interrupts and wakeup
  // ----------------------------------------
  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      done_f_q  <= 1'b0;
      acc_f_q   <= 1'b0;
      cedge_f_q <= 1'b0;
      irq_q     <= 1'b0;
      cirq_q    <= 1'b0;
      wake_q    <= 1'b0;
      lp_out_q  <= 1'b0;
    end else begin
      if (done_q) begin
        done_f_q <= 1'b1;
      end else if (wr_stat && WDATA[adcc_pkg::S_DONE]) begin
        done_f_q <= 1'b0;
      end
      if (acc_last_q) begin
        acc_f_q <= 1'b1;
      end else if (wr_stat && WDATA[adcc_pkg::S_ACCD]) begin
        acc_f_q <= 1'b0;
      end
      if (cmp_act) begin
        cedge_f_q <= 1'b1;
      end else if (wr_stat && WDATA[adcc_pkg::S_CEDGE]) begin
        cedge_f_q <= 1'b0;
      end
      irq_q    <= irq_en_q && ((acc_en_q && acc_irq_q) ? acc_f_q : done_f_q);
      cirq_q   <= cirq_en_q && cedge_f_q;
      wake_q   <= SLEEP && cwake_q && cmp_act;
      lp_out_q <= clp_q || SLEEP;
    end
  end
  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= 32'h0000_0000;
      if (RD) begin
        unique case (ADDR)
          adcc_pkg::CTRL_OFS: rdata_q <= {16'h0000, irq_en_q, acc_irq_q, accn_q, acc_en_q, refx_q,
                                          gain_q, smp_q, div_q, chan_q, cont_q, 1'b0};
          adcc_pkg::STAT_OFS: rdata_q <= {27'h0, cedge_f_q, cmp_f_q, acc_f_q, done_f_q,
                                          (st_q != adcc_pkg::ST_IDLE) || start_q};
          adcc_pkg::RES_OFS:  rdata_q <= {24'h000000, res_q};
          adcc_pkg::ACC_OFS:  rdata_q <= 32'(accsum_q);
          adcc_pkg::CMPC_OFS: rdata_q <= {22'h0, cirq_en_q, cfall_q, cwake_q, cpos_q, cneg_q,
                                          chys_q, clp_q, cen_q};
          default:            rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign RDATA         = rdata_q;
  assign ADC_SAMPLE    = samp_q;
  assign ADC_CHAN      = chan_q;
  assign ADC_TRIAL     = trial_q;
  assign ADC_GAIN      = gain_q;
  assign ADC_REF_EXT   = refx_q;
  assign ADC_SUPMON_EN = sup_q;
  assign ADC_IRQ       = irq_q;
  assign CMP_EN        = cen_q;
  assign CMP_LOWPWR    = lp_out_q;
  assign CMP_HYST      = chys_q;
  assign CMP_NEG_SEL   = cneg_q;
  assign CMP_POS_SEL   = cpos_q;
  assign CMP_IRQ       = cirq_q;
  assign WAKE          = wake_q;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [5:0] len_q;
  logic [4:0] stk_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      len_q <= 6'h00;
      stk_q <= 5'h00;
    end else begin
      if (done_q) begin
        len_q <= 6'h00;
      end else if (adc_tk_q && (st_q != adcc_pkg::ST_IDLE)) begin
        len_q <= 6'(len_q + 6'h01);
      end
      stk_q <= samp_q ? 5'(stk_q + {4'h0, adc_tk_q}) : 5'h00;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence s_last_bit;
    adc_tk_q && (st_q == adcc_pkg::ST_CONV) && (bit_q == 3'h0);
  endsequence

  a_samp_len: assert property ($fell(samp_q) |-> stk_q == samp_n)
    else $error("sample phase length wrong");
  a_conv_len: assert property (done_q |-> len_q == 6'(samp_n * 3 + 10))
    else $error("conversion length wrong");
  a_cont_next: assert property (s_last_bit ##0 cont_q |=> st_q == adcc_pkg::ST_SAMP ##0 samp_q)
    else $error("continuous mode did not restart");
  a_single_stop: assert property (s_last_bit ##0 !cont_q |=> st_q == adcc_pkg::ST_IDLE ##0 done_q)
    else $error("single mode did not stop");
  a_chan_legal: assert property (ADC_CHAN <= 3'h5)
    else $error("illegal channel selected");
  a_supmon_gate: assert property (ADC_SUPMON_EN |-> $past(chan_q) == 3'h5)
    else $error("supply divider on outside supply measurement");
  a_done_flag: assert property (done_q |=> done_f_q ##1 (ADC_IRQ || !$past(irq_en_q) || $past(acc_en_q && acc_irq_q)))
    else $error("completion not flagged");
  a_acc_clear: assert property (done_q && acc_en_q && acc_cnt_q == 4'h0 |=> acc_q == {{(ACC_W-8){1'b0}}, res_q})
    else $error("accumulator not cleared at period start");
  a_acc_period: assert property (acc_last_q |-> $past(acc_cnt_q) == $past(acc_top))
    else $error("accumulation period count wrong");
  a_sleep_lowpwr: assert property (SLEEP |=> CMP_LOWPWR)
    else $error("low-power mode not forced in sleep");
  a_wake_cause: assert property (WAKE |-> $past(SLEEP && cwake_q && cen_q))
    else $error("wakeup without enabled sleep event");
endmodule : adcc_top

// ### bench/adcc_analog_model.sv
// Purpose: Analogue side of the converter and comparator.
// Assumes: Each channel carries a fixed level; the bench moves the comparator input.
// Notes:   A divider or comparator that is switched off reads low.
`timescale 1ns/1ns
module adcc_analog_model (
  input  wire logic       clk,
  input  wire logic       sample,
  input  wire logic [2:0] chan,
  input  wire logic [7:0] trial,
  input  wire logic       supmon_en,
  input  wire logic       cmp_en,
  input  wire logic       cmp_level,
  output logic            adc_cmp,
  output logic            cmp_out
);
  logic [7:0] held_q;
  // The held level is frozen when the sample switch opens.
  always_ff @(posedge clk) begin
    if (sample) begin
      held_q <= (chan == 3'h5 && !supmon_en) ? 8'h00 : 8'h21 + {chan, 4'h3};
    end
  end
  assign adc_cmp = (held_q >= trial);
  // The comparator output follows the bench level while enabled and reads low while switched off.
  assign cmp_out = cmp_en & cmp_level;
endmodule : adcc_analog_model

// ### bench/adcc_top_tb.sv
// Purpose: Self-checking bench of the converter and comparator control.
// Assumes: Source tick on four of every five clocks, so one 2 MHz tick is ten clocks.
// Notes:   Channel levels follow the analogue model.
`timescale 1ns/1ns
module adcc_top_tb;
  logic        CLK = 0, RST_N = 0, SRC_TICK = 0, WR = 0, RD = 0, SLEEP = 0, cmp_level = 0;
  logic [7:0]  ADDR = 8'h00, ADC_TRIAL;
  logic [31:0] WDATA = 32'h0, RDATA, rd_q;
  logic [2:0]  ADC_CHAN, src_cnt = 3'h0;
  logic [1:0]  CMP_HYST, CMP_NEG_SEL;
  logic        ADC_CMP, CMP_OUT, ADC_SAMPLE, ADC_GAIN, ADC_REF_EXT, ADC_SUPMON_EN, ADC_IRQ;
  logic        CMP_EN, CMP_LOWPWR, CMP_POS_SEL, CMP_IRQ, WAKE;
  int          n_mismatch = 0, cmp_count = 0, cyc = 0, n;
  adcc_top DUT (.CLK, .RST_N, .SRC_TICK, .ADDR, .WDATA, .WR, .RD, .RDATA, .ADC_CMP, .ADC_SAMPLE,
    .ADC_CHAN, .ADC_TRIAL, .ADC_GAIN, .ADC_REF_EXT, .ADC_SUPMON_EN, .ADC_IRQ, .SLEEP, .CMP_OUT,
    .CMP_EN, .CMP_LOWPWR, .CMP_HYST, .CMP_NEG_SEL, .CMP_POS_SEL, .CMP_IRQ, .WAKE);
  adcc_analog_model ana (.clk(CLK), .sample(ADC_SAMPLE), .chan(ADC_CHAN), .trial(ADC_TRIAL),
    .supmon_en(ADC_SUPMON_EN), .cmp_en(CMP_EN), .cmp_level(cmp_level), .adc_cmp(ADC_CMP), .cmp_out(CMP_OUT));
  always #25 CLK = ~CLK;
  always @(posedge CLK) begin
    src_cnt <= (src_cnt == 3'h4) ? 3'h0 : src_cnt + 3'h1;
    SRC_TICK <= (src_cnt != 3'h4);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end
  function automatic logic [7:0] lev(input logic [2:0] c);
    return 8'h21 + {c, 4'h3};
  endfunction : lev
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 rd_q = RDATA;
  endtask : rd
  // Counts edges until the signal shows the level; the bound keeps a hang short.
  task automatic wait_lvl(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 3000) begin
      @(posedge CLK);
      #1 n++;
    end
  endtask : wait_lvl
  task automatic t_reset();
    rd(adcc_pkg::CTRL_OFS);
    chk(rd_q, adcc_pkg::CTRL_RST);
    rd(adcc_pkg::CMPC_OFS);
    chk(rd_q, adcc_pkg::CMPC_RST);
    rd(8'h40);
    chk(rd_q, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_single();
    wr(adcc_pkg::CTRL_OFS, 32'h0000_8085);
    wait_lvl(ADC_SAMPLE, 1'b1);
    wait_lvl(ADC_SAMPLE, 1'b0);
    chk(n, 40);
    wait_lvl(ADC_IRQ, 1'b1);
    chk(n >= 179 && n <= 183, 1);
    rd(adcc_pkg::RES_OFS);
    chk(rd_q, lev(3'h1));
    rd(adcc_pkg::STAT_OFS);
    chk(rd_q[1:0], 2'h2);
    wr(adcc_pkg::STAT_OFS, 32'h2);
    @(posedge CLK);
    #1 chk(ADC_IRQ, 1'b0);
    $display("test single done");
  endtask : t_single
  task automatic t_accum();
    wr(adcc_pkg::CTRL_OFS, 32'h0000_DE2F);
    #1 chk({ADC_GAIN, ADC_REF_EXT}, 2'h3);
    for (int k = 0; k < 2; k++) begin
      wait_lvl(ADC_IRQ, 1'b1);
      chk(n >= 1270, 1);
      rd(adcc_pkg::ACC_OFS);
      chk(rd_q, 32'h0000_0150);
      wr(adcc_pkg::STAT_OFS, 32'h6);
      repeat (2) @(posedge CLK);
    end
    wr(adcc_pkg::CTRL_OFS, 32'h0);
    rd_q = 32'h1;
    for (int k = 0; k < 250 && rd_q[0] !== 1'b0; k++) rd(adcc_pkg::STAT_OFS);
    chk(rd_q[0], 1'b0);
    $display("test accumulate done");
  endtask : t_accum
  task automatic t_supply();
    wr(adcc_pkg::STAT_OFS, 32'h16);
    chk(ADC_SUPMON_EN, 1'b0);
    wr(adcc_pkg::CTRL_OFS, 32'h0000_83F5);
    wait_lvl(ADC_SUPMON_EN, 1'b1);
    chk(n <= 3, 1);
    wr(adcc_pkg::CTRL_OFS, 32'h0000_83F8);
    #1 chk(ADC_CHAN, adcc_pkg::CHAN_SUPPLY);
    wait_lvl(ADC_IRQ, 1'b1);
    chk(n >= 2720 && n <= 2799, 1);
    rd(adcc_pkg::RES_OFS);
    chk(rd_q, lev(3'h5));
    chk(ADC_SUPMON_EN, 1'b0);
    $display("test supply done");
  endtask : t_supply
  task automatic t_comp();
    wr(adcc_pkg::CMPC_OFS, 32'h0000_02DD);
    #1 chk({CMP_EN, CMP_HYST, CMP_NEG_SEL, CMP_POS_SEL}, 6'h3B);
    wr(adcc_pkg::CMPC_OFS, 32'h0000_02FD);
    #1 chk(CMP_NEG_SEL, 2'h1);
    @(posedge CLK);
    SLEEP <= 1'b1;
    cmp_level <= 1'b1;
    wait_lvl(WAKE, 1'b1);
    chk(n <= 6, 1);
    @(posedge CLK);
    #1 chk(WAKE, 1'b0);
    chk({CMP_LOWPWR, CMP_IRQ}, 2'h3);
    rd(adcc_pkg::STAT_OFS);
    chk(rd_q[4:3], 2'h3);
    wr(adcc_pkg::STAT_OFS, 32'h10);
    cmp_level <= 1'b0;
    wait_lvl(WAKE, 1'b1);
    chk(n, 3000);
    wr(adcc_pkg::CMPC_OFS, 32'h0000_03DD);
    cmp_level <= 1'b1;
    repeat (8) @(posedge CLK);
    rd(adcc_pkg::STAT_OFS);
    chk(rd_q[4:3], 2'h1);
    @(posedge CLK);
    cmp_level <= 1'b0;
    wait_lvl(WAKE, 1'b1);
    chk(n <= 6, 1);
    wr(adcc_pkg::CMPC_OFS, 32'h0);
    SLEEP <= 1'b0;
    #1 chk(CMP_EN, 1'b0);
    $display("test comparator done");
  endtask : t_comp
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial begin
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLK);
    t_reset();
    t_single();
    t_accum();
    t_supply();
    t_comp();
    complete_run();
  end
endmodule : adcc_top_tb
